// >>> core/dma_seq_defs.vh
// Constants for the four-channel DMA sequencer: register map, control word fields,
// descriptor layout, address step modes, access sizes and channel state codes.
// Included by the sequencer only; holds definitions only.
`ifndef DMA_SEQ_DEFS_VH
`define DMA_SEQ_DEFS_VH

// Register map: paddr[6:5] picks the channel, paddr[4:0] the register
`define OFF_CTL 5'h00
`define OFF_DST 5'h04
`define OFF_SRC 5'h08
`define OFF_CNT 5'h0c
`define OFF_LIST 5'h10
`define OFF_SEL 5'h14
`define OFF_WM 5'h18
`define ADDR_BW 8'h80
`define ADDR_CH_TOP 8'h7f

// Control word fields (same layout in the descriptor)
`define CTL_EN 15
`define CTL_KEEP 14
`define CTL_WID_HI 13
`define CTL_WID_LO 12
`define CTL_DST_HI 11
`define CTL_DST_LO 10
`define CTL_SRC_HI 9
`define CTL_SRC_LO 8
`define CTL_IRQ 7
`define CTL_NXT 6
`define CTL_FE 5
`define CTL_HALT 4
`define CTL_CMD_HI 3
`define CTL_CMD_LO 0

// Address step modes
`define STEP_INC 2'h1
`define STEP_DEC 2'h2

// Descriptor offsets from the list pointer
`define DESC_CTL 24'h000000
`define DESC_CNT 24'h000002
`define DESC_DST 24'h000004
`define DESC_SRC 24'h000008
`define DESC_NXT 24'h00000c
`define DESC_SIZE 24'h000010
`define DESC_ALIGN_MASK 24'hfffff0

// Memory access sizes
`define SIZE_HALF 2'h1
`define SIZE_QUAD 2'h2

// Channel state codes shown in the select register
`define CS_OFF 4'h0
`define CS_D_FIRST 4'h4
`define CS_L_FIRST 4'h5
`define CS_D_BUSY 4'h6
`define CS_L_BUSY 4'h7
`define CS_D_CLOSE 4'h8
`define CS_L_NEW 4'h9
`define CS_L_CLOSE 4'ha

`endif

// >>> core/dma_closure_modes_arbiter.v
// Four-channel DMA sequencer: direct and descriptor-list operation, buffer closure,
// round-robin channel choice and a throttle against CPU bus use.
// Assumes on-chip peripherals and the CPU on clk_sys, and a bus arbiter and
// memory port that acknowledge each access with a one-cycle memAck.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "dma_seq_defs.vh"

module dma_closure_modes_arbiter (
    input wire clk_sys,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [15:0] reqLines,
    input wire [3:0] frameCloseReq,
    input wire [15:0] periphStatus,
    input wire cpuOpDone,
    output reg [3:0] periphAck,
    output reg cmdValid,
    output reg [3:0] cmdBus,
    output reg eofSync,
    output reg [3:0] readStatus,
    output reg [3:0] chanIrq,
    output reg busReq,
    input wire busGrant,
    output reg memReq,
    output reg memWrite,
    output reg [1:0] memSize,
    output reg [23:0] memAddr,
    output reg [31:0] memWdata,
    input wire memAck,
    input wire [31:0] memRdata
);

    localparam S_IDLE = 4'h0;
    localparam S_FCTL = 4'h1;
    localparam S_FDST = 4'h2;
    localparam S_FSRC = 4'h3;
    localparam S_FCNT = 4'h4;
    localparam S_RD = 4'h5;
    localparam S_WR = 4'h6;
    localparam S_CLOSE = 4'h7;
    localparam S_STAT = 4'h8;
    localparam S_WBC = 4'h9;
    localparam S_WBN = 4'ha;
    localparam S_ADV = 4'hb;
    localparam S_NXT = 4'hc;

    reg [15:0] ctl_q [0:3];
    reg [23:0] dst_q [0:3];
    reg [23:0] src_q [0:3];
    reg [15:0] cnt_q [0:3];
    reg [23:0] lp_q [0:3];
    reg [3:0] sel_q [0:3];
    reg [7:0] wm_q [0:3];
    reg [3:0] listMode_q;
    reg [3:0] fetchPend_q;
    reg [3:0] fcPend_q;
    reg [3:0] reqPend_q;
    reg [3:0] firstXfer_q;
    reg [15:0] reqPrev_q;
    reg [1:0] bwLimit_q;
    reg [1:0] bwGap_q;
    reg [3:0] st_q;
    reg [1:0] ch_q;
    reg [1:0] last_q;
    reg [31:0] data_q;
    integer i;
    integer chn;

    wire apbWr = psel & penable & pready & pwrite;
    wire [1:0] pch = paddr[6:5];
    wire [4:0] poff = paddr[4:0];
    wire [15:0] reqRise = reqLines & ~reqPrev_q;
    wire memDone = memReq & memAck;
    wire bwOk = (bwGap_q == 2'h0);

    function [23:0] stepAddr;
        input [23:0] a;
        input [1:0] mode;
        input [1:0] wid;
        reg [23:0] inc;
        begin
            inc = 24'h000001 << wid;
            if (mode == `STEP_INC) begin
                stepAddr = a + inc;
            end else if (mode == `STEP_DEC) begin
                stepAddr = a - inc;
            end else begin
                stepAddr = a;
            end
        end
    endfunction

    function [1:0] pickRr;
        input [3:0] want;
        input [1:0] last;
        reg [1:0] k;
        reg [1:0] idx;
        reg found;
        integer j;
        begin
            pickRr = last;
            found = 1'b0;
            for (j = 1; j <= 4; j = j + 1) begin
                k = j[1:0];
                idx = last + k;
                if (!found && want[idx]) begin
                    pickRr = idx;
                    found = 1'b1;
                end
            end
        end
    endfunction

    function [3:0] chanState;
        input [15:0] c;
        input lm;
        input fp;
        input cl;
        input first;
        begin
            if (fp) begin
                chanState = `CS_L_NEW;
            end else if (!c[`CTL_EN]) begin
                chanState = `CS_OFF;
            end else if (cl) begin
                chanState = lm ? `CS_L_CLOSE : `CS_D_CLOSE;
            end else if (first) begin
                chanState = lm ? `CS_L_FIRST : `CS_D_FIRST;
            end else begin
                chanState = lm ? `CS_L_BUSY : `CS_D_BUSY;
            end
        end
    endfunction

    // Per-channel service needs
    reg [3:0] closeNeed;
    reg [3:0] want;
    always @* begin
        for (chn = 0; chn < 4; chn = chn + 1) begin
            closeNeed[chn] = ctl_q[chn][`CTL_EN] & ((cnt_q[chn] == 16'h0000) | fcPend_q[chn]);
            want[chn] = fetchPend_q[chn] | closeNeed[chn] | (ctl_q[chn][`CTL_EN] & reqPend_q[chn] & bwOk);
        end
    end
    wire [1:0] winner = pickRr(want, last_q);

    // Current channel fields
    wire [15:0] cctl = ctl_q[ch_q];
    wire [1:0] cwid = cctl[`CTL_WID_HI:`CTL_WID_LO];
    wire curList = listMode_q[ch_q];
    wire curFe = cctl[`CTL_FE];

    // APB read data, registered in the setup cycle so pready comes next
    reg [31:0] rdData;
    reg rdErr;
    always @* begin
        rdData = 32'h00000000;
        rdErr = 1'b0;
        if (paddr == `ADDR_BW) begin
            rdData = {30'h00000000, bwLimit_q};
        end else if (paddr > `ADDR_CH_TOP) begin
            rdErr = 1'b1;
        end else if (poff == `OFF_CTL) begin
            rdData = {16'h0000, ctl_q[pch]};
        end else if (poff == `OFF_DST) begin
            rdData = {8'h00, dst_q[pch]};
        end else if (poff == `OFF_SRC) begin
            rdData = {8'h00, src_q[pch]};
        end else if (poff == `OFF_CNT) begin
            rdData = {16'h0000, cnt_q[pch]};
        end else if (poff == `OFF_LIST) begin
            rdData = {8'h00, lp_q[pch]};
        end else if (poff == `OFF_SEL) begin
            rdData = {24'h000000, chanState(ctl_q[pch], listMode_q[pch], fetchPend_q[pch],
                closeNeed[pch], firstXfer_q[pch]), sel_q[pch]};
        end else if (poff == `OFF_WM) begin
            rdData = {24'h000000, wm_q[pch]};
        end else begin
            rdErr = 1'b1;
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & rdErr;
            prdata <= (psel & ~penable & ~pwrite) ? rdData : 32'h00000000;
        end
    end

    // Throttle: after each data transfer wait for bwLimit CPU operations
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bwGap_q <= 2'h0;
        end else if (st_q == S_WR && memDone) begin
            bwGap_q <= bwLimit_q;
        end else if (cpuOpDone && bwGap_q != 2'h0) begin
            bwGap_q <= bwGap_q - 2'h1;
        end
    end

    // Software writes first; the engine below overrides in the same cycle
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < 4; i = i + 1) begin
                ctl_q[i] <= 16'h0000;
                dst_q[i] <= 24'h000000;
                src_q[i] <= 24'h000000;
                cnt_q[i] <= 16'h0000;
                lp_q[i] <= 24'h000000;
                sel_q[i] <= 4'h0;
                wm_q[i] <= 8'h00;
            end
            listMode_q <= 4'h0;
            fetchPend_q <= 4'h0;
            fcPend_q <= 4'h0;
            reqPend_q <= 4'h0;
            firstXfer_q <= 4'h0;
            reqPrev_q <= 16'h0000;
            bwLimit_q <= 2'h0;
            st_q <= S_IDLE;
            ch_q <= 2'h0;
            last_q <= 2'h3;
            data_q <= 32'h00000000;
            periphAck <= 4'h0;
            cmdValid <= 1'b0;
            cmdBus <= 4'h0;
            eofSync <= 1'b0;
            readStatus <= 4'h0;
            chanIrq <= 4'h0;
            busReq <= 1'b0;
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memSize <= 2'h0;
            memAddr <= 24'h000000;
            memWdata <= 32'h00000000;
        end else begin
            reqPrev_q <= reqLines;
            cmdValid <= 1'b0;
            eofSync <= 1'b0;
            chanIrq <= 4'h0;
            readStatus <= 4'h0;
            if (apbWr) begin
                if (paddr == `ADDR_BW) begin
                    bwLimit_q <= pwdata[1:0];
                end else if (paddr > `ADDR_CH_TOP) begin
                    bwLimit_q <= bwLimit_q;
                end else if (poff == `OFF_CTL) begin
                    ctl_q[pch] <= pwdata[15:0];
                    listMode_q[pch] <= 1'b0;
                    firstXfer_q[pch] <= 1'b1;
                    fcPend_q[pch] <= 1'b0;
                end else if (poff == `OFF_DST) begin
                    dst_q[pch] <= pwdata[23:0];
                end else if (poff == `OFF_SRC) begin
                    src_q[pch] <= pwdata[23:0];
                end else if (poff == `OFF_CNT) begin
                    cnt_q[pch] <= pwdata[15:0];
                end else if (poff == `OFF_LIST) begin
                    lp_q[pch] <= pwdata[23:0] & `DESC_ALIGN_MASK;
                    fetchPend_q[pch] <= 1'b1;
                end else if (poff == `OFF_SEL) begin
                    sel_q[pch] <= pwdata[3:0];
                end else if (poff == `OFF_WM) begin
                    wm_q[pch] <= pwdata[7:0];
                end
            end
            case (st_q)
                S_IDLE: begin
                    busReq <= |want;
                    periphAck <= 4'h0;
                    if (|want && busGrant) begin
                        ch_q <= winner;
                        last_q <= winner;
                        if (fetchPend_q[winner]) begin
                            st_q <= S_FCTL;
                        end else if (closeNeed[winner]) begin
                            st_q <= S_CLOSE;
                        end else begin
                            st_q <= S_RD;
                            periphAck[winner] <= 1'b1;
                        end
                    end
                end
                S_FCTL, S_FDST, S_FSRC, S_FCNT, S_RD, S_NXT: begin
                    // Reads; fetch order is fixed by the state sequence
                    if (!memReq) begin
                        memReq <= 1'b1;
                        memWrite <= 1'b0;
                        memSize <= (st_q == S_FCTL || st_q == S_FCNT) ? `SIZE_HALF :
                            (st_q == S_RD) ? cwid : `SIZE_QUAD;
                        memAddr <= (st_q == S_FCTL) ? lp_q[ch_q] + `DESC_CTL :
                            (st_q == S_FDST) ? lp_q[ch_q] + `DESC_DST :
                            (st_q == S_FSRC) ? lp_q[ch_q] + `DESC_SRC :
                            (st_q == S_FCNT) ? lp_q[ch_q] + `DESC_CNT :
                            (st_q == S_NXT) ? lp_q[ch_q] + `DESC_NXT : src_q[ch_q];
                    end else if (memAck) begin
                        memReq <= 1'b0;
                        case (st_q)
                            S_FCTL: begin
                                ctl_q[ch_q] <= memRdata[15:0];
                                st_q <= S_FDST;
                            end
                            S_FDST: begin
                                dst_q[ch_q] <= memRdata[23:0];
                                st_q <= S_FSRC;
                            end
                            S_FSRC: begin
                                src_q[ch_q] <= memRdata[23:0];
                                st_q <= S_FCNT;
                            end
                            S_FCNT: begin
                                cnt_q[ch_q] <= memRdata[15:0];
                                fetchPend_q[ch_q] <= 1'b0;
                                listMode_q[ch_q] <= 1'b1;
                                firstXfer_q[ch_q] <= 1'b1;
                                fcPend_q[ch_q] <= 1'b0;
                                reqPend_q[ch_q] <= sel_q[ch_q] == 4'h0;
                                st_q <= S_IDLE;
                            end
                            S_NXT: begin
                                lp_q[ch_q] <= memRdata[23:0] & `DESC_ALIGN_MASK;
                                fetchPend_q[ch_q] <= ~cctl[`CTL_HALT];
                                st_q <= S_IDLE;
                            end
                            default: begin
                                data_q <= memRdata;
                                st_q <= S_WR;
                            end
                        endcase
                    end
                end
                S_WR: begin
                    if (!memReq) begin
                        memReq <= 1'b1;
                        memWrite <= 1'b1;
                        memSize <= cwid;
                        memAddr <= dst_q[ch_q];
                        memWdata <= data_q;
                        cmdValid <= firstXfer_q[ch_q];
                        cmdBus <= cctl[`CTL_CMD_HI:`CTL_CMD_LO];
                        eofSync <= curFe & (cnt_q[ch_q] == 16'h0001);
                    end else if (memAck) begin
                        memReq <= 1'b0;
                        periphAck <= 4'h0;
                        cnt_q[ch_q] <= cnt_q[ch_q] - 16'h0001;
                        reqPend_q[ch_q] <= (sel_q[ch_q] == 4'h0) | reqRise[sel_q[ch_q]];
                        firstXfer_q[ch_q] <= 1'b0;
                        src_q[ch_q] <= stepAddr(src_q[ch_q], cctl[`CTL_SRC_HI:`CTL_SRC_LO], cwid);
                        dst_q[ch_q] <= stepAddr(dst_q[ch_q], cctl[`CTL_DST_HI:`CTL_DST_LO], cwid);
                        // Watermark interrupt lets software refill before the buffer drains
                        if (!curList && cctl[`CTL_IRQ] && wm_q[ch_q] != 8'h00 &&
                            cnt_q[ch_q] - 16'h0001 == {8'h00, wm_q[ch_q]}) begin
                            chanIrq[ch_q] <= 1'b1;
                        end
                        st_q <= S_IDLE;
                    end
                end
                S_CLOSE: begin
                    // One closure even if zero count and frame-close coincide
                    ctl_q[ch_q][`CTL_EN] <= 1'b0;
                    ctl_q[ch_q][`CTL_FE] <= curFe | fcPend_q[ch_q];
                    fcPend_q[ch_q] <= 1'b0;
                    chanIrq[ch_q] <= cctl[`CTL_IRQ] | fcPend_q[ch_q];
                    if (curFe | fcPend_q[ch_q]) begin
                        readStatus[ch_q] <= 1'b1;
                        st_q <= S_STAT;
                    end else begin
                        st_q <= (curList & ~cctl[`CTL_KEEP]) ? S_WBC : S_ADV;
                    end
                end
                S_STAT: begin
                    ctl_q[ch_q][`CTL_CMD_HI:`CTL_CMD_LO] <= periphStatus[ch_q * 4 +: 4];
                    st_q <= (curList & ~cctl[`CTL_KEEP]) ? S_WBC : S_ADV;
                end
                S_WBC, S_WBN: begin
                    if (!memReq) begin
                        memReq <= 1'b1;
                        memWrite <= 1'b1;
                        memSize <= `SIZE_HALF;
                        memAddr <= lp_q[ch_q] + ((st_q == S_WBC) ? `DESC_CTL : `DESC_CNT);
                        memWdata <= {16'h0000, (st_q == S_WBC) ? cctl : cnt_q[ch_q]};
                    end else if (memAck) begin
                        memReq <= 1'b0;
                        st_q <= (st_q == S_WBC && curFe) ? S_WBN : S_ADV;
                    end
                end
                S_ADV: begin
                    if (!curList) begin
                        st_q <= S_IDLE;
                    end else if (cctl[`CTL_NXT]) begin
                        st_q <= S_NXT;
                    end else begin
                        lp_q[ch_q] <= lp_q[ch_q] + `DESC_SIZE;
                        fetchPend_q[ch_q] <= ~cctl[`CTL_HALT];
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
            // Capture last: an event wins over a clear above in the same cycle
            for (i = 0; i < 4; i = i + 1) begin
                if (frameCloseReq[i] && ctl_q[i][`CTL_EN]) begin
                    fcPend_q[i] <= 1'b1;
                end
                if ((sel_q[i] == 4'h0) || reqRise[sel_q[i]]) begin
                    reqPend_q[i] <= 1'b1;
                end
            end
        end
    end

endmodule // dma_closure_modes_arbiter

// >>> sim/dma_mem_model.sv
// Memory port and bus arbiter partner for the DMA sequencer.
// Assumes little-endian bytes in the low bits of the word and addresses below 0x100.
`timescale 1ns/100ps
module dma_mem_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic busReq,
    output logic busGrant,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [1:0] memSize,
    input wire logic [23:0] memAddr,
    input wire logic [31:0] memWdata,
    output logic memAck,
    output logic [31:0] memRdata
);
    logic [7:0] mem [0:255];
    logic [23:0] rdLog [$];
    logic [1:0] waitCnt;
    logic slow;
    logic [7:0] a;
    assign a = memAddr[7:0];
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busGrant <= 1'b0;
            memAck <= 1'b0;
            memRdata <= 32'h0;
            waitCnt <= 2'h0;
            slow <= 1'b0;
        end else begin
            busGrant <= busReq;
            if (memReq && !memAck && waitCnt != 2'h0) begin
                waitCnt <= waitCnt - 2'h1;
            end else if (memReq && !memAck) begin
                memAck <= 1'b1;
                slow <= !slow;
                if (memWrite) begin
                    mem[a] <= memWdata[7:0];
                    if (memSize != 2'h0) mem[a + 8'h1] <= memWdata[15:8];
                    if (memSize == 2'h2) mem[a + 8'h2] <= memWdata[23:16];
                    if (memSize == 2'h2) mem[a + 8'h3] <= memWdata[31:24];
                end else begin
                    rdLog.push_back(memAddr);
                    memRdata <= {mem[a + 8'h3], mem[a + 8'h2], mem[a + 8'h1], mem[a]}
                        & (memSize == 2'h2 ? 32'hffffffff : memSize == 2'h1 ? 32'hffff : 32'hff);
                end
            end else begin
                // Released data changes so stale values cannot pass
                memAck <= 1'b0;
                memRdata <= ~memRdata;
                waitCnt <= slow ? 2'h3 : 2'h0;
            end
        end
    end
endmodule // dma_mem_model

// >>> sim/dma_seq_checker.sv
// Port-level assertions for the DMA sequencer.
// Assumes memAck is a one-cycle pulse; bound in by the bench.
`timescale 1ns/100ps
module dma_seq_checker (
    input wire clk_sys,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire [3:0] periphAck,
    input wire [3:0] readStatus,
    input wire [3:0] chanIrq,
    input wire busReq,
    input wire memReq,
    input wire memAck,
    input wire [1:0] memSize,
    input wire [23:0] memAddr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence accWait; memReq && !memAck; endsequence
    sequence accDone; memReq && memAck; endsequence
    sequence descAcc; memReq && periphAck == 4'h0; endsequence
    a_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready late");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_mem_hold: assert property (accWait |=> memReq && $stable(memAddr) && $stable(memSize))
        else $error("memory request changed before ack");
    a_mem_gap: assert property (accDone |=> !memReq)
        else $error("no idle cycle after access");
    a_desc_align: assert property (descAcc |-> memAddr[3:0] inside {4'h0, 4'h2, 4'h4, 4'h8, 4'hc})
        else $error("descriptor access off its slot");
    a_ctl_half: assert property (descAcc and memAddr[3:0] == 4'h0 |-> memSize == 2'h1)
        else $error("control word not a half access");
    a_one_channel: assert property ($onehot0(periphAck))
        else $error("two channels serviced at once");
    a_bus_first: assert property ($rose(|periphAck) |-> $past(busReq))
        else $error("transfer without bus request");
    a_status_pulse: assert property (|readStatus |=> readStatus == 4'h0)
        else $error("status strobe too long");
    a_irq_pulse: assert property (|chanIrq |=> (chanIrq & $past(chanIrq)) == 4'h0)
        else $error("interrupt pulse too long");
endmodule // dma_seq_checker

// >>> sim/dma_closure_modes_arbiter_tb.sv
// Self-checking bench for the DMA sequencer: APB master, peripheral stimulus, memory partner.
// Assumes zero-wait APB answers and all buffers below byte address 0x100.
`timescale 1ns/100ps
module dma_closure_modes_arbiter_tb;
    logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, cpuOpDone = 0, e;
    logic pready, pslverr, cmdValid, eofSync, busReq, busGrant, memReq, memWrite, memAck;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, memWdata, memRdata, q, lfsr = 32'hcc0ffb3a;
    logic [15:0] reqLines = 0, periphStatus = 0;
    logic [3:0] frameCloseReq = 0, periphAck, readStatus, chanIrq, cmdBus, irqSeen = 0, rsSeen = 0, cmdSeen = 0;
    logic [1:0] memSize, bw;
    logic [23:0] memAddr;
    int error_cnt = 0, total_checks = 0, n, cmdCnt = 0, eofCnt = 0;
    int ofs[4] = '{0, 4, 8, 2};
    dma_closure_modes_arbiter dut_u (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .reqLines, .frameCloseReq, .periphStatus, .cpuOpDone, .periphAck,
        .cmdValid, .cmdBus, .eofSync, .readStatus, .chanIrq, .busReq, .busGrant, .memReq, .memWrite,
        .memSize, .memAddr, .memWdata, .memAck, .memRdata);
    dma_mem_model mdl_u (.clk_sys, .nrst, .busReq, .busGrant, .memReq, .memWrite, .memSize,
        .memAddr, .memWdata, .memAck, .memRdata);
    initial forever #50 clk_sys = ~clk_sys;
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always @(posedge clk_sys) begin
        lfsr <= step(lfsr);
        cpuOpDone <= lfsr[3];
        reqLines <= {lfsr[15:2], 2'b00};
        // Outputs are unknown until the first reset edge
        if (nrst) begin
            irqSeen <= irqSeen | chanIrq;
            rsSeen <= rsSeen | readStatus;
            eofCnt <= eofCnt + eofSync;
            if (cmdValid) cmdSeen <= cmdBus;
            if (cmdValid) cmdCnt <= cmdCnt + 1;
        end
    end
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++k < 50);
        if (pready !== 1'b1) error_cnt++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitFor(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        repeat (300) begin
            apb(0, a, 0);
            if ((q & m) === v) break;
        end
    endtask
    task automatic put(input int a, input logic [31:0] d, input int nb);
        for (int i = 0; i < nb; i++) mdl_u.mem[a + i] = d[8 * i +: 8];
    endtask
    function automatic logic [31:0] get(input int a, input int nb);
        logic [31:0] r;
        r = 0;
        for (int i = 0; i < nb; i++) r[8 * i +: 8] = mdl_u.mem[a + i];
        return r;
    endfunction
    task automatic desc(input int a, input logic [15:0] c, input int cnt, input int d, input int s);
        put(a, c, 2);
        put(a + 2, cnt, 2);
        put(a + 4, d, 4);
        put(a + 8, s, 4);
        put(a + 12, 0, 4);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk_sys);
        error_cnt++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        periphStatus <= lfsr[15:0];
        apb(0, 8'h00, 0);
        chk("ctl0 reset", 0, q);
        apb(0, 8'h14, 0);
        chk("sel0 reset", 0, q);
        apb(1, 8'h84, 1);
        chk("unmapped wr err", 1, e);
        apb(0, 8'h84, 0);
        chk("unmapped rd data", 0, q);
        chk("unmapped rd err", 1, e);
        bw = lfsr[1:0];
        apb(1, 8'h80, {30'h0, bw});
        apb(0, 8'h80, 0);
        chk("bandwidth", {30'h0, bw}, q);
        n = 1 + lfsr[1:0];
        put(8'hc0, lfsr, 4);
        apb(1, 8'h14, 0);
        apb(1, 8'h04, 32'he0);
        apb(1, 8'h08, 32'hc0);
        apb(1, 8'h0c, n);
        apb(1, 8'h18, 0);
        apb(1, 8'h00, 32'h8583);
        waitFor(8'h00, 32'h8000, 0);
        apb(0, 8'h00, 0);
        chk("ctl0 closed", 32'h0583, q);
        apb(0, 8'h0c, 0);
        chk("cnt0", 0, q);
        apb(0, 8'h14, 0);
        chk("state0", 0, q & 32'hf0);
        chk("dst0", get(8'hc0, n), get(8'he0, n));
        chk("irq0", 1, irqSeen[0]);
        chk("rdstat0", 0, rsSeen[0]);
        chk("cmd0", 3, cmdSeen);
        apb(1, 8'h34, 1);
        apb(1, 8'h2c, 5);
        apb(1, 8'h20, 32'h8005);
        frameCloseReq <= 4'h2;
        waitFor(8'h20, 32'h8000, 0);
        frameCloseReq <= 4'h0;
        apb(0, 8'h20, 0);
        chk("ctl1 closed", 32'h20 | periphStatus[7:4], q);
        apb(0, 8'h2c, 0);
        chk("cnt1", 5, q);
        chk("irq1", 1, irqSeen[1]);
        chk("rdstat1", 1, rsSeen[1]);
        desc(8'h40, 16'h8500, 2, 8'ha0, 8'h80);
        desc(8'h50, 16'hc530, 1, 8'hb0, 8'h90);
        put(8'h80, lfsr, 2);
        put(8'h90, ~lfsr, 1);
        apb(1, 8'h54, 0);
        mdl_u.rdLog.delete();
        apb(1, 8'h50, 32'h40);
        waitFor(8'h50, 32'hff, 32'h60);
        waitFor(8'h54, 32'hf0, 0);
        chk("halted", 0, q & 32'hf0);
        for (int i = 0; i < 4; i++) chk("fetch order", 8'h40 + ofs[i], mdl_u.rdLog[i]);
        chk("wb0", 32'h0500, get(8'h40, 2));
        chk("keep1", 32'hc530, get(8'h50, 2));
        chk("data2", get(8'h80, 2), get(8'ha0, 2));
        chk("data3", get(8'h90, 1), get(8'hb0, 1));
        apb(0, 8'h50, 0);
        chk("list2", 32'h60, q);
        apb(0, 8'h40, 0);
        chk("ctl2", 32'h4530 | periphStatus[11:8], q);
        chk("irq2", 0, irqSeen[2]);
        chk("rdstat2", 1, rsSeen[2]);
        chk("cmd count", 3, cmdCnt);
        chk("eof sync", 1, eofCnt);
        close_out;
    end
endmodule // dma_closure_modes_arbiter_tb
bind dma_closure_modes_arbiter dma_seq_checker chk_u (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .periphAck(periphAck), .readStatus(readStatus),
    .chanIrq(chanIrq), .busReq(busReq), .memReq(memReq), .memAck(memAck), .memSize(memSize), .memAddr(memAddr));
